/* File: hw/compare_skip_decoder.sv */
`timescale 1ns/100ps
`include "compare_skip_params.svh"

module compare_skip_decoder
  import compare_skip_pkg::*;
#(
  parameter int BANK_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [15:0]       instr_word,
  input  wire logic              instr_valid,
  input  wire logic              next_two_word,
  input  wire logic [7:0]        working_register,
  input  wire logic [BANK_W-1:0] bank_select_register,
  input  wire logic              extended_enable,
  input  wire logic [11:0]       index_base,
  input  wire logic [7:0]        data_rdata,
  output logic                   instr_ready,
  output logic      [1:0]        q_phase,
  output data_req_t              data_req,
  output logic                   exec_nop,
  output result_t                result
);

  if (BANK_W < 1 || BANK_W > 4) begin : g_bank_check
    $error("BANK_W must be 1..4");
  end

  typedef enum logic [2:0] {
    st_decode,
    st_read,
    st_process,
    st_nowrite,
    st_skip
  } state_t;

  function automatic compare_op_t decode_op(input logic [15:0] w);
    logic [6:0] opc;
    opc = w[`CSD_OPC_MSB:`CSD_OPC_LSB];
    if (opc == `CSD_OPC_EQUAL) begin
      decode_op = op_equal;
    end else if (opc == `CSD_OPC_GREATER) begin
      decode_op = op_greater;
    end else begin
      decode_op = op_none;
    end
  endfunction

  function automatic logic compare_hit(input compare_op_t op, input logic [7:0] f,
                                       input logic [7:0] w);
    logic [8:0] diff;
    diff = {1'b0, f} - {1'b0, w};
    compare_hit = (op == op_equal)   ? (diff == 9'h000) :
                  (op == op_greater) ? (!diff[8] && diff != 9'h000) : 1'b0;
  endfunction

  state_t      state_reg;
  state_t      state_next;
  decoded_t    dec_reg;
  decoded_t    dec_next;
  logic [1:0]  phase_reg;
  logic [1:0]  skip_left_reg;
  logic [1:0]  skip_left_next;
  logic [1:0]  cycles_reg;
  logic [1:0]  cycles_next;
  logic        hit_reg;
  logic        two_word_reg;
  data_req_t   req_reg;
  data_req_t   req_next;
  result_t     res_reg;
  result_t     res_next;
  logic [11:0] op_addr;
  addr_mode_t  op_mode;

  wire compare_op_t in_op  = decode_op(instr_word);
  wire decoded_t    in_dec = '{op:         in_op,
                               access_sel: instr_word[`CSD_ACCESS_BIT],
                               file_addr:  instr_word[`CSD_FILE_MSB:`CSD_FILE_LSB]};
  wire              accept = (state_reg == st_decode) && instr_valid;
  wire              last_q = phase_reg == 2'(`CSD_PHASES - 3'd1);
  // unsigned compare on the read byte
  wire              hit_now = compare_hit(dec_reg.op, data_rdata, working_register);

  operand_address_unit #(
    .BANK_W (BANK_W)
  ) u_addr (
    .access_sel           (in_dec.access_sel),
    .file_addr            (in_dec.file_addr),
    .bank_select_register (bank_select_register),
    .extended_enable      (extended_enable),
    .index_base           (index_base),
    .addr                 (op_addr),
    .mode                 (op_mode)
  );

  assign instr_ready = state_reg == st_decode;
  assign q_phase     = phase_reg;
  assign data_req    = req_reg;
  assign exec_nop    = state_reg == st_skip;
  assign result      = res_reg;

  always_comb begin
    state_next     = state_reg;
    dec_next       = dec_reg;
    skip_left_next = skip_left_reg;
    cycles_next    = cycles_reg;
    req_next       = '{rd: 1'b0, addr: req_reg.addr, mode: req_reg.mode};
    res_next       = '{done: 1'b0, is_compare: res_reg.is_compare,
                       skip: res_reg.skip, cycles: res_reg.cycles};
    unique case (state_reg)
      st_decode: begin
        if (accept) begin
          dec_next    = in_dec;
          cycles_next = 2'd1;
          state_next  = st_read;
          // read strobe stands in second phase
          if (in_op != op_none) begin
            req_next = '{rd: 1'b1, addr: op_addr, mode: op_mode};
          end
        end
      end
      st_read: begin
        state_next = st_process;
      end
      st_process: begin
        state_next = st_nowrite;
      end
      st_nowrite: begin
        if (hit_reg) begin
          skip_left_next = two_word_reg ? 2'd2 : 2'd1;
          cycles_next    = two_word_reg ? 2'd3 : 2'd2;
          state_next     = st_skip;
        end else begin
          res_next   = '{done: 1'b1, is_compare: dec_reg.op != op_none,
                         skip: 1'b0, cycles: cycles_reg};
          state_next = st_decode;
        end
      end
      st_skip: begin
        if (last_q) begin
          skip_left_next = skip_left_reg - 2'd1;
          if (skip_left_reg == 2'd1) begin
            res_next   = '{done: 1'b1, is_compare: 1'b1, skip: 1'b1,
                           cycles: cycles_reg};
            state_next = st_decode;
          end
        end
      end
    endcase
  end

  // phase counter: one clock per phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= `CSD_PHASE_RESET;
    end else if (state_reg == st_skip) begin
      phase_reg <= phase_reg + 2'd1;
    end else if (state_next == st_decode || accept) begin
      phase_reg <= accept ? 2'd1 : `CSD_PHASE_RESET;
    end else begin
      phase_reg <= phase_reg + 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= st_decode;
      dec_reg       <= '{op: op_none, access_sel: 1'b0, file_addr: 8'h00};
      skip_left_reg <= 2'd0;
      cycles_reg    <= 2'd0;
      req_reg       <= '{rd: 1'b0, addr: `CSD_ADDR_RESET, mode: mode_access};
      res_reg       <= '{done: 1'b0, is_compare: 1'b0, skip: 1'b0, cycles: 2'd0};
    end else begin
      state_reg     <= state_next;
      dec_reg       <= dec_next;
      skip_left_reg <= skip_left_next;
      cycles_reg    <= cycles_next;
      req_reg       <= req_next;
      res_reg       <= res_next;
    end
  end

  // compare result caught in the process phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_reg      <= 1'b0;
      two_word_reg <= 1'b0;
    end else if (accept) begin
      hit_reg      <= 1'b0;
      two_word_reg <= next_two_word;
    end else if (state_reg == st_process) begin
      hit_reg <= hit_now;
    end
  end

endmodule

/* File: hw/compare_skip_params.svh */
`ifndef COMPARE_SKIP_PARAMS_SVH
`define COMPARE_SKIP_PARAMS_SVH

// opcode field: bits 15..9 of the program word
`define CSD_OPC_MSB        4'd15
`define CSD_OPC_LSB        4'd9
`define CSD_OPC_EQUAL      7'h31
`define CSD_OPC_GREATER    7'h32
// access-select bit and file address field
`define CSD_ACCESS_BIT     4'd8
`define CSD_FILE_MSB       4'd7
`define CSD_FILE_LSB       4'd0
// highest file address that uses indexed literal offset
`define CSD_INDEXED_MAX    8'h5f
// access bank split: below it low ram, at or above it the top bank
`define CSD_ACCESS_SPLIT   8'h60
`define CSD_ACCESS_HI_BANK 4'hf
// phases per instruction cycle and reset values
`define CSD_PHASES         3'd4
`define CSD_ADDR_RESET     12'h000
`define CSD_PHASE_RESET    2'h0

`endif

/* File: hw/compare_skip_pkg.sv */
package compare_skip_pkg;

  typedef enum logic [1:0] {
    op_none,
    op_equal,
    op_greater
  } compare_op_t;

  typedef enum logic [1:0] {
    mode_access,
    mode_banked,
    mode_indexed
  } addr_mode_t;

  typedef struct packed {
    compare_op_t op;
    logic        access_sel;
    logic [7:0]  file_addr;
  } decoded_t;

  typedef struct packed {
    logic       rd;
    logic [11:0] addr;
    addr_mode_t mode;
  } data_req_t;

  typedef struct packed {
    logic       done;
    logic       is_compare;
    logic       skip;
    logic [1:0] cycles;
  } result_t;

endpackage

/* File: hw/operand_address_unit.sv */
`timescale 1ns/100ps
`include "compare_skip_params.svh"

module operand_address_unit
  import compare_skip_pkg::*;
#(
  parameter int BANK_W = 4
) (
  input  wire logic              access_sel,
  input  wire logic [7:0]        file_addr,
  input  wire logic [BANK_W-1:0] bank_select_register,
  input  wire logic              extended_enable,
  input  wire logic [11:0]       index_base,
  output logic      [11:0]       addr,
  output addr_mode_t             mode
);

  if (BANK_W < 1 || BANK_W > 4) begin : g_bank_check
    $error("BANK_W must be 1..4");
  end

  wire        indexed   = !access_sel && extended_enable && (file_addr <= `CSD_INDEXED_MAX);
  wire        low_half  = file_addr < `CSD_ACCESS_SPLIT;
  wire [3:0]  bank_wide = 4'(bank_select_register);
  wire [11:0] banked    = {bank_wide, file_addr};
  wire [11:0] access    = low_half ? {4'h0, file_addr} : {`CSD_ACCESS_HI_BANK, file_addr};
  wire [11:0] idx_sum   = index_base + {4'h0, file_addr};

  assign addr = indexed ? idx_sum : (access_sel ? banked : access);
  assign mode = indexed ? mode_indexed : (access_sel ? mode_banked : mode_access);

endmodule

/* File: tb/compare_skip_assertions.sv */
`timescale 1ns/100ps
module compare_skip_checker
  import compare_skip_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [1:0]  q_phase,
  input wire data_req_t   data_req,
  input wire logic        exec_nop,
  input wire result_t     result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire take = instr_valid && instr_ready;
  wire cmp  = instr_word[15:9] == 7'h31 || instr_word[15:9] == 7'h32;
  sequence s_take_cmp;
    take && cmp;
  endsequence
  sequence s_nop_cycle;
    exec_nop [*4];
  endsequence
  a_read_phase: assert property (s_take_cmp |=> data_req.rd && q_phase == 2'h1)
    else $error("file read not in second phase");
  a_busy_span: assert property (take |=> !instr_ready [*3])
    else $error("decoder ready too early");
  a_other_done: assert property (take && !cmp |-> ##4 result.done && !result.is_compare)
    else $error("other opcode not finished in one cycle");
  a_nop_whole: assert property ($rose(exec_nop) |-> s_nop_cycle)
    else $error("no-op cycle shorter than four phases");
  a_nop_quiet: assert property (exec_nop |-> !data_req.rd && !instr_ready)
    else $error("activity during no-op cycle");
  a_skip_nop: assert property (result.done && result.skip |-> $past(exec_nop) && result.is_compare)
    else $error("skip finished without no-op");
  a_plain_one: assert property (result.done && !result.skip |-> result.cycles == 2'd1)
    else $error("plain compare cycle count wrong");
  a_long_skip: assert property (result.done && result.cycles == 2'd3 |-> $past(exec_nop, 8) && result.skip)
    else $error("two-word skip without two no-op cycles");
endmodule
bind compare_skip_decoder compare_skip_checker u_chk (.clk(clk), .rst_b(rst_b),
  .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .q_phase(q_phase), .data_req(data_req), .exec_nop(exec_nop), .result(result));

/* File: tb/test_compare_skip_decoder.sv */
`timescale 1ns/100ps
module test_compare_skip_decoder import compare_skip_pkg::*;;
  logic        clk, rst_b, instr_valid, next_two_word, extended_enable;
  logic        instr_ready, exec_nop;
  logic [15:0] instr_word;
  logic [7:0]  working_register, data_rdata;
  logic [3:0]  bank_select_register;
  logic [11:0] index_base;
  logic [1:0]  q_phase;
  data_req_t   data_req;
  result_t     result;
  int          n_errors = 0;
  int          n_tests = 0;
  compare_skip_decoder u_dut (.clk(clk), .rst_b(rst_b), .instr_word(instr_word),
    .instr_valid(instr_valid), .next_two_word(next_two_word),
    .working_register(working_register), .bank_select_register(bank_select_register),
    .extended_enable(extended_enable), .index_base(index_base), .data_rdata(data_rdata),
    .instr_ready(instr_ready), .q_phase(q_phase), .data_req(data_req),
    .exec_nop(exec_nop), .result(result));
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task run(input logic [15:0] word, input logic [7:0] w, input logic [7:0] d,
           input logic two, input logic [1:0] cyc, input logic [11:0] ad, input addr_mode_t md);
    int   n, nops, rds;
    logic c;
    n = 0;
    nops = 0;
    rds = 0;
    c = word[15:9] == 7'h31 || word[15:9] == 7'h32;
    @(posedge clk);
    working_register <= w;
    data_rdata <= d;
    next_two_word <= two;
    instr_word <= word;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      nops += exec_nop;
      rds += data_req.rd;
    end while (result.done !== 1'b1 && n < 20);
    chk("clocks", 4 * cyc, n);
    chk("nop_clocks", 4 * (cyc - 1), nops);
    chk("skip", cyc != 2'd1, result.skip);
    chk("is_compare", c, result.is_compare);
    chk("reads", c, rds);
    if (c) begin
      chk("cycles", cyc, result.cycles);
      chk("addr", ad, data_req.addr);
      chk("mode", md, data_req.mode);
    end
  endtask
  task t_greater_access;
    extended_enable <= 1'b0;
    run(16'h6420, 8'h10, 8'h11, 1'b0, 2'd2, 12'h020, mode_access);
    run(16'h64a5, 8'h80, 8'h7f, 1'b0, 2'd1, 12'hfa5, mode_access);
    run(16'h64a5, 8'h7f, 8'h80, 1'b0, 2'd2, 12'hfa5, mode_access);
    run(16'h6410, 8'h33, 8'h33, 1'b0, 2'd1, 12'h010, mode_access);
  endtask
  task t_banked_two_word;
    extended_enable <= 1'b1;
    bank_select_register <= 4'h3;
    run(16'h65ff, 8'h00, 8'hff, 1'b1, 2'd3, 12'h3ff, mode_banked);
    run(16'h6300, 8'h44, 8'h44, 1'b1, 2'd3, 12'h300, mode_banked);
  endtask
  task t_equal_indexed;
    extended_enable <= 1'b1;
    index_base <= 12'h100;
    run(16'h625f, 8'h5a, 8'h5a, 1'b0, 2'd2, 12'h15f, mode_indexed);
    run(16'h6260, 8'h01, 8'h02, 1'b0, 2'd1, 12'hf60, mode_access);
  endtask
  task t_other_opcode;
    run(16'h6020, 8'h00, 8'hff, 1'b0, 2'd1, 12'h000, mode_access);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    next_two_word = 1'b0;
    extended_enable = 1'b0;
    instr_word = 16'h0000;
    working_register = 8'h00;
    data_rdata = 8'h00;
    bank_select_register = 4'h0;
    index_base = 12'h000;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_greater_access();
    t_banked_two_word();
    t_equal_indexed();
    t_other_opcode();
    end_of_test();
  end
endmodule
